// file: bench/adcsq_analog_model.sv
// ****************************************
// Analog mux and ladder comparator
// ****************************************
module adcsq_analog_model (
	input wire logic clk,
	input wire logic [3:0] mux_channel,
	input wire logic [7:0] ladder_code,
	input wire logic ladder_current_on,
	input wire logic [95:0] levels,
	output logic comp_above
);
	timeunit 1ns;
	timeprecision 1ps;
	logic junk = 1'b0;
	logic [7:0] lvl;
	// No ladder current: output is noise, never a held answer
	always @(posedge clk) begin
		junk <= ~junk;
	end
	always_comb begin
		lvl = (mux_channel < 4'hc) ? levels[mux_channel*8 +: 8] : 8'h00;
		comp_above = ladder_current_on ? (lvl >= ladder_code) : junk;
	end
endmodule : adcsq_analog_model

// file: bench/adcsq_top_tb.sv
module adcsq_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, hsel, hwrite, stop_mode, watch_mode, subactive_mode;
	logic hreadyout, hresp, comp_above, ladder_current_on, conv_busy;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd, sxs;
	logic [3:0] mux_channel;
	logic [7:0] ladder_code, res;
	logic [11:0] analog_pin_en, port_data_out, pullup_on;
	logic [95:0] levels;
	int err_count, n_checks, cyc, busy_n;

	adcsq_top u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .stop_mode(stop_mode), .watch_mode(watch_mode),
		.subactive_mode(subactive_mode), .comp_above(comp_above),
		.mux_channel(mux_channel), .ladder_code(ladder_code),
		.ladder_current_on(ladder_current_on), .analog_pin_en(analog_pin_en),
		.port_data_out(port_data_out), .pullup_on(pullup_on),
		.conv_busy(conv_busy));
	adcsq_analog_model u_ana (.clk(clk), .mux_channel(mux_channel),
		.ladder_code(ladder_code), .ladder_current_on(ladder_current_on),
		.levels(levels), .comp_above(comp_above));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs();
		sxs = sxs ^ (sxs << 13);
		sxs = sxs ^ (sxs >> 17);
		sxs = sxs ^ (sxs << 5);
		return sxs;
	endfunction : xs

	// Ideal successive approximation against the level
	function automatic logic [7:0] sar_exp(input logic [7:0] v);
		logic [7:0] c;
		c = 8'h00;
		for (int b = 7; b >= 0; b--) begin
			if (v >= (c | (8'h01 << b))) begin
				c = c | (8'h01 << b);
			end
		end
		return c;
	endfunction : sar_exp

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	// One single-word transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [9:0] idx,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {20'h0, idx, 2'h0};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask : bus

	task automatic get_res();
		bus(1'b0, adcsq_pkg::IDX_RES_LO, 32'h0);
		res[3:0] = rd[3:0];
		bus(1'b0, adcsq_pkg::IDX_RES_HI, 32'h0);
		res[7:4] = rd[3:0];
	endtask : get_res

	task automatic settle();
		repeat (3) @(posedge clk);
	endtask : settle

	// Start only when idle; freeze holds watch mode mid-run
	task automatic convert(input logic [3:0] ch, input logic slow,
		input int freeze);
		bus(1'b1, adcsq_pkg::IDX_CHAN, {28'h0, ch});
		bus(1'b1, adcsq_pkg::IDX_SPEED_MODE, {31'h0, slow});
		bus(1'b1, adcsq_pkg::IDX_START, 32'h4);
		busy_n = 0;
		@(posedge clk);
		while (conv_busy === 1'b1 && busy_n < 500) begin
			busy_n++;
			watch_mode <= (busy_n >= 6 && busy_n < 6 + freeze);
			@(posedge clk);
		end
		watch_mode <= 1'b0;
		chk("channel", ch, mux_channel);
		chk("cycles", 8 * (slow ? 8 : 4) + freeze, busy_n);
		bus(1'b0, adcsq_pkg::IDX_START, 32'h0);
		chk("start flag", 32'h0, {31'h0, rd[2]});
		get_res();
		chk("result", sar_exp(levels[ch*8 +: 8]), res);
	endtask : convert

	// ****************************************
	// Clock and hang limit
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			summarize();
		end
	end

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		{rst, hsel, hwrite, stop_mode, watch_mode, subactive_mode} = 6'h20;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		sxs = 32'h8;
		for (int i = 0; i < 12; i++) levels[i*8 +: 8] = 8'(xs());
		levels[15:0] = 16'hff00;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		settle();
		chk("port data", 32'hfff, port_data_out);
		chk("pin enables", 32'h0, analog_pin_en);
		chk("pullups", 32'h0, pullup_on);
		bus(1'b0, 10'h3ff, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("hresp", 32'h0, hresp);
		for (int i = 0; i < 4; i++) begin
			res = 8'(xs());
			bus(1'b1, adcsq_pkg::IDX_PIN_MODE1, {28'h0, res[3:0]});
			bus(1'b1, adcsq_pkg::IDX_SPEED_MODE, {28'h0, res[7:4]});
			settle();
			chk("pins", {res[7], res[7], res[7], res[7], res[6], res[6],
				res[5], res[5], res[3:0]}, analog_pin_en);
		end
		for (int i = 0; i < 12; i++) begin
			convert(i[3:0], i[0], (i == 5) ? 3 : 0);
		end
		bus(1'b1, adcsq_pkg::IDX_RES_LO, 32'h5);
		levels = ~levels;
		rst <= 1'b1;
		settle();
		rst <= 1'b0;
		get_res();
		chk("result held", sar_exp(~levels[95:88]), res);
		bus(1'b1, adcsq_pkg::IDX_LADDER, 32'h4);
		settle();
		chk("ladder off", 32'h0, ladder_current_on);
		bus(1'b1, adcsq_pkg::IDX_LADDER, 32'h0);
		settle();
		chk("ladder on", 32'h1, ladder_current_on);
		for (int m = 0; m < 3; m++) begin
			{stop_mode, watch_mode, subactive_mode} <= 3'h1 << m;
			settle();
			chk("low power ladder", 32'h0, ladder_current_on);
			{stop_mode, watch_mode, subactive_mode} <= 3'h0;
			settle();
		end
		bus(1'b1, adcsq_pkg::IDX_PIN_MODE1, 32'hf);
		bus(1'b1, adcsq_pkg::IDX_PORT_DATA, 32'h0);
		bus(1'b1, adcsq_pkg::IDX_START, 32'h4);
		settle();
		stop_mode <= 1'b1;
		settle();
		chk("stop busy", 32'h0, conv_busy);
		chk("stop pins", 32'h0, analog_pin_en);
		chk("stop data", 32'hfff, port_data_out);
		stop_mode <= 1'b0;
		get_res();
		chk("result after stop", sar_exp(~levels[95:88]), res);
		bus(1'b1, adcsq_pkg::IDX_PULLUP, 32'h8);
		settle();
		chk("pullup on", 32'hfff, pullup_on);
		bus(1'b1, adcsq_pkg::IDX_PORT_DATA, 32'h0);
		settle();
		chk("pullup released", 32'h0, pullup_on);
		summarize();
	end
endmodule : adcsq_top_tb

// file: design/adcsq_pkg.sv
package adcsq_pkg;

	// ****************************************
	// Register word indexes (byte address = 4 * index)
	// ****************************************
	localparam logic [9:0] IDX_CHAN = 10'h016;
	localparam logic [9:0] IDX_RES_LO = 10'h017;
	localparam logic [9:0] IDX_RES_HI = 10'h018;
	localparam logic [9:0] IDX_PIN_MODE1 = 10'h019;
	localparam logic [9:0] IDX_SPEED_MODE = 10'h01a;
	localparam logic [9:0] IDX_START = 10'h020;
	localparam logic [9:0] IDX_LADDER = 10'h021;
	localparam logic [9:0] IDX_PORT_DATA = 10'h022;
	localparam logic [9:0] IDX_PULLUP = 10'h023;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_START = 2;
	localparam int BIT_LADDER_OFF = 2;
	localparam int BIT_PULLUP = 3;
	localparam int BIT_SPEED = 0;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [3:0] RESET_NIBBLE = 4'h0;
	localparam logic [11:0] RESET_PORT_DATA = 12'hfff;

	// ****************************************
	// Timing: time per result bit, rounded up to clocks
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int BIT_TIME_FAST_NS = 40;
	localparam int BIT_TIME_SLOW_NS = 80;
	localparam int CYC_FAST =
		(BIT_TIME_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_SLOW =
		(BIT_TIME_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic {
		SAR_IDLE,
		SAR_CONV
	} adcsq_sar_state_e;

	typedef enum logic {
		BUS_IDLE,
		BUS_RD_WAIT
	} adcsq_bus_state_e;

endpackage : adcsq_pkg

// file: design/adcsq_sar.sv
// ****************************************
// Successive-approximation step engine
// ****************************************
module adcsq_sar #(
	parameter int RES_W = 8,
	parameter int CNT_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic run,
	input wire logic [CNT_W-1:0] cycles_per_bit,
	input wire logic comp_above,
	output logic [RES_W-1:0] trial_code,
	output logic busy,
	output logic done,
	output logic [RES_W-1:0] result
);
	adcsq_pkg::adcsq_sar_state_e state_reg, state_next;
	logic [RES_W-1:0] code_reg, code_next;
	logic [RES_W-1:0] mask_reg, mask_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [RES_W-1:0] decided;

	always_comb begin
		state_next = state_reg;
		code_next = code_reg;
		mask_next = mask_reg;
		cnt_next = cnt_reg;
		done = 1'b0;
		// Comparator says input is below the trial: drop the bit
		decided = comp_above ? code_reg : (code_reg & ~mask_reg);
		case (state_reg)
			adcsq_pkg::SAR_IDLE: begin
				if (start) begin
					state_next = adcsq_pkg::SAR_CONV;
					mask_next = {1'b1, {(RES_W-1){1'b0}}};
					code_next = {1'b1, {(RES_W-1){1'b0}}};
					cnt_next = '0;
				end
			end
			adcsq_pkg::SAR_CONV: begin
				// Frozen while the system clock is away
				if (run) begin
					if (cnt_reg == cycles_per_bit - 1'b1) begin
						cnt_next = '0;
						if (mask_reg[0]) begin
							done = 1'b1;
							code_next = decided;
							state_next = adcsq_pkg::SAR_IDLE;
						end else begin
							code_next = decided | (mask_reg >> 1);
							mask_next = mask_reg >> 1;
						end
					end else begin
						cnt_next = cnt_reg + 1'b1;
					end
				end
			end
			default: state_next = adcsq_pkg::SAR_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= adcsq_pkg::SAR_IDLE;
			code_reg <= '0;
			mask_reg <= '0;
			cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			code_reg <= code_next;
			mask_reg <= mask_next;
			cnt_reg <= cnt_next;
		end
	end

	assign trial_code = code_reg;
	assign busy = (state_reg == adcsq_pkg::SAR_CONV);
	assign result = decided;

endmodule : adcsq_sar

// file: design/adcsq_top.sv
// How it works
// (RULE1) One of twelve inputs converts to 8 bits by successive comparison.
// (RULE2) First pin mode register picks digital or analog for pins 0 to 3.
// (RULE3) Second pin mode register sets speed and analog use of pins 4 to 11.
// (RULE4) Channel register picks the input routed to the comparator.
// (RULE5) Writing one to start flag bit 2 begins a conversion.
// (RULE6) On completion the result loads and the start flag clears together.
// (RULE7) Ladder-off flag bit 2 set cuts ladder current in any mode.
// (RULE8) Result is read only, split into low and high nibble registers.
// (RULE9) Reset does not clear the result.
// (RULE10) A finished result holds until the next conversion starts.
// (RULE11) Result reads during a conversion give no guaranteed value.
// (RULE12) Software must not write the start flag while converting.
// (RULE13) Software sets the start flag only by single-bit set instructions.
// (RULE14) No conversion progress in stop, watch or subactive mode.
// (RULE15) Low-power modes cut ladder current whatever the off flag holds.
// (RULE16) Reset sets all port data bits; pull-up enable then pulls pins up.
// (RULE17) Analog pins keep pull-up while enable is set and data bit is one.
// (RULE18) Software clears the data bit of a pin used as analog input.
// (RULE19) Stop mode resets control and cancels all analog pin assignments.
// (RULE20) Each speed setting gives a fixed clock count per result bit.
//
// The AHB-Lite slave port was chosen for this implementation.
module adcsq_top #(
	parameter int N_CHAN = 12,
	parameter int RES_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic stop_mode,
	input wire logic watch_mode,
	input wire logic subactive_mode,
	input wire logic comp_above,
	output logic [3:0] mux_channel,
	output logic [RES_W-1:0] ladder_code,
	output logic ladder_current_on,
	output logic [N_CHAN-1:0] analog_pin_en,
	output logic [N_CHAN-1:0] port_data_out,
	output logic [N_CHAN-1:0] pullup_on,
	output logic conv_busy
);
	// ****************************************
	// Bus slave
	// ****************************************
	adcsq_pkg::adcsq_bus_state_e bus_reg, bus_next;
	logic wr_pend_reg, wr_pend_next;
	logic [9:0] idx_reg, idx_next;
	logic addr_ok_reg, addr_ok_next;
	logic [31:0] rdata_reg, rdata_next;
	logic addr_fire;
	logic wr_fire;

	function automatic logic [9:0] word_index(input logic [31:0] a);
		return a[11:2];
	endfunction : word_index

	function automatic logic addr_valid(input logic [31:0] a);
		return (a[1:0] == 2'b00) && (a[31:12] == 20'h00000);
	endfunction : addr_valid

	// ****************************************
	// Control state
	// ****************************************
	logic ctrl_rst;
	logic low_power;
	logic [3:0] chan_reg, chan_next;
	logic [3:0] mode1_reg, mode1_next;
	logic [3:0] mode2_reg, mode2_next;
	logic start_reg, start_next;
	logic ladder_off_reg, ladder_off_next;
	logic pullup_en_reg, pullup_en_next;
	logic [N_CHAN-1:0] pdata_reg, pdata_next;
	logic [RES_W-1:0] result_reg;
	logic ladder_on_reg, ladder_on_next;
	logic [N_CHAN-1:0] apin_reg, apin_next;
	logic sar_start;
	logic sar_busy;
	logic sar_done;
	logic [RES_W-1:0] sar_result;
	logic [7:0] cycles_per_bit;

	// Stop mode acts as a reset of the control state only
	assign ctrl_rst = rst | stop_mode; // [RULE19]
	assign low_power = stop_mode | watch_mode | subactive_mode;
	assign addr_fire = hsel & htrans[1] & hready;
	assign wr_fire = wr_pend_reg;

	always_comb begin
		bus_next = bus_reg;
		wr_pend_next = 1'b0;
		idx_next = idx_reg;
		addr_ok_next = addr_ok_reg;
		rdata_next = rdata_reg;
		hreadyout = 1'b1;
		case (bus_reg)
			adcsq_pkg::BUS_IDLE: begin
				if (addr_fire) begin
					idx_next = word_index(haddr);
					addr_ok_next = addr_valid(haddr);
					wr_pend_next = hwrite;
					if (!hwrite) begin
						bus_next = adcsq_pkg::BUS_RD_WAIT;
					end
				end
			end
			adcsq_pkg::BUS_RD_WAIT: begin
				// One wait state so a read sees any write just before it
				hreadyout = 1'b0;
				rdata_next = '0;
				if (addr_ok_reg) begin
					case (idx_reg)
						adcsq_pkg::IDX_CHAN: rdata_next[3:0] = chan_reg;
						adcsq_pkg::IDX_RES_LO:
							rdata_next[3:0] = result_reg[3:0]; // [RULE8]
						adcsq_pkg::IDX_RES_HI:
							rdata_next[3:0] = result_reg[7:4]; // [RULE8] [RULE11]
						adcsq_pkg::IDX_PIN_MODE1: rdata_next[3:0] = mode1_reg;
						adcsq_pkg::IDX_SPEED_MODE: rdata_next[3:0] = mode2_reg;
						adcsq_pkg::IDX_START:
							rdata_next[adcsq_pkg::BIT_START] = start_reg;
						adcsq_pkg::IDX_LADDER:
							rdata_next[adcsq_pkg::BIT_LADDER_OFF] = ladder_off_reg;
						adcsq_pkg::IDX_PORT_DATA:
							rdata_next[N_CHAN-1:0] = pdata_reg;
						adcsq_pkg::IDX_PULLUP:
							rdata_next[adcsq_pkg::BIT_PULLUP] = pullup_en_reg;
						default: rdata_next = '0;
					endcase
				end
				bus_next = adcsq_pkg::BUS_IDLE;
			end
			default: bus_next = adcsq_pkg::BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bus_reg <= adcsq_pkg::BUS_IDLE;
			wr_pend_reg <= 1'b0;
			idx_reg <= '0;
			addr_ok_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			bus_reg <= bus_next;
			wr_pend_reg <= wr_pend_next;
			idx_reg <= idx_next;
			addr_ok_reg <= addr_ok_next;
			rdata_reg <= rdata_next;
		end
	end

	assign hresp = 1'b0;
	assign hrdata = rdata_reg;

	// ****************************************
	// Register writes and conversion control
	// ****************************************
	// Start only when idle: a start written mid-conversion is dropped
	assign sar_start = wr_fire & addr_ok_reg & (idx_reg == adcsq_pkg::IDX_START)
		& hwdata[adcsq_pkg::BIT_START] & ~start_reg & ~low_power; // [RULE5]

	always_comb begin
		chan_next = chan_reg;
		mode1_next = mode1_reg;
		mode2_next = mode2_reg;
		start_next = start_reg;
		ladder_off_next = ladder_off_reg;
		pullup_en_next = pullup_en_reg;
		pdata_next = pdata_reg;
		if (wr_fire && addr_ok_reg) begin
			case (idx_reg)
				adcsq_pkg::IDX_CHAN: chan_next = hwdata[3:0]; // [RULE4]
				adcsq_pkg::IDX_PIN_MODE1: mode1_next = hwdata[3:0]; // [RULE2]
				adcsq_pkg::IDX_SPEED_MODE: mode2_next = hwdata[3:0]; // [RULE3]
				adcsq_pkg::IDX_LADDER:
					ladder_off_next = hwdata[adcsq_pkg::BIT_LADDER_OFF];
				adcsq_pkg::IDX_PORT_DATA: pdata_next = hwdata[N_CHAN-1:0];
				adcsq_pkg::IDX_PULLUP:
					pullup_en_next = hwdata[adcsq_pkg::BIT_PULLUP];
				default: chan_next = chan_reg;
			endcase
		end
		if (sar_start) begin
			start_next = 1'b1; // [RULE5]
		end else if (sar_done) begin
			start_next = 1'b0; // [RULE6]
		end
		// Pins 0-3 one bit each; pins 4-5, 6-7, 8-11 by groups
		apin_next = {{4{mode2_reg[3]}}, {2{mode2_reg[2]}},
			{2{mode2_reg[1]}}, mode1_reg}; // [RULE2] [RULE3]
		ladder_on_next = ~ladder_off_reg & ~low_power; // [RULE7] [RULE15]
	end

	always_ff @(posedge clk) begin
		if (ctrl_rst) begin
			chan_reg <= adcsq_pkg::RESET_NIBBLE;
			mode1_reg <= adcsq_pkg::RESET_NIBBLE;
			mode2_reg <= adcsq_pkg::RESET_NIBBLE;
			start_reg <= 1'b0;
			ladder_off_reg <= 1'b0;
			pullup_en_reg <= 1'b0;
			pdata_reg <= adcsq_pkg::RESET_PORT_DATA; // [RULE16]
			apin_reg <= '0; // [RULE19]
			ladder_on_reg <= 1'b0;
		end else begin
			chan_reg <= chan_next;
			mode1_reg <= mode1_next;
			mode2_reg <= mode2_next;
			start_reg <= start_next;
			ladder_off_reg <= ladder_off_next;
			pullup_en_reg <= pullup_en_next;
			pdata_reg <= pdata_next;
			apin_reg <= apin_next;
			ladder_on_reg <= ladder_on_next;
		end
	end

	// No reset: the last result survives reset and stop
	always_ff @(posedge clk) begin
		if (sar_done) begin
			result_reg <= sar_result; // [RULE6] [RULE9] [RULE10]
		end
	end

	assign cycles_per_bit = mode2_reg[adcsq_pkg::BIT_SPEED]
		? 8'(adcsq_pkg::CYC_SLOW) : 8'(adcsq_pkg::CYC_FAST); // [RULE20]

	adcsq_sar #(
		.RES_W(RES_W),
		.CNT_W(8)
	) u_sar (
		.clk(clk),
		.rst(ctrl_rst),
		.start(sar_start),
		.run(~low_power), // [RULE14]
		.cycles_per_bit(cycles_per_bit),
		.comp_above(comp_above), // [RULE1]
		.trial_code(ladder_code),
		.busy(sar_busy),
		.done(sar_done),
		.result(sar_result)
	);

	assign mux_channel = chan_reg; // [RULE4]
	assign ladder_current_on = ladder_on_reg;
	assign analog_pin_en = apin_reg;
	assign port_data_out = pdata_reg;
	// Pull-up follows data bit even on analog pins
	assign pullup_on = pullup_en_reg ? pdata_reg : '0; // [RULE16] [RULE17]
	assign conv_busy = sar_busy;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_fast_start;
		sar_start && !mode2_reg[adcsq_pkg::BIT_SPEED];
	endsequence

	// Low power may freeze or abort a run, but never ends it early
	sequence s_no_early_done;
		(!sar_done) [*8];
	endsequence

	sequence s_frozen_step;
		(watch_mode || subactive_mode) && !stop_mode && sar_busy;
	endsequence

	a_start_sets_flag: assert property ( // [RULE5]
		sar_start |=> start_reg && sar_busy)
		else $error("start did not raise flag");
	a_done_clears_flag: assert property ( // [RULE6]
		sar_done && !stop_mode |=>
		!start_reg && result_reg == $past(sar_result))
		else $error("done did not load result and clear flag");
	// Case equality: the result is unknown until the first completion
	a_result_holds: assert property ( // [RULE10]
		!sar_done |=> result_reg === $past(result_reg))
		else $error("result changed without completion");
	a_ladder_off: assert property ( // [RULE7]
		ladder_off_reg |=> !ladder_current_on)
		else $error("ladder current on while off flag set");
	a_lowpower_ladder: assert property ( // [RULE15]
		low_power |=> !ladder_current_on)
		else $error("ladder current on in low power");
	// Done looked at in the frozen cycle: a resume may finish the next one
	a_lowpower_freeze: assert property ( // [RULE14]
		s_frozen_step |-> !sar_done ##1 $stable(ladder_code))
		else $error("conversion advanced in low power");
	a_stop_cancels: assert property ( // [RULE19]
		stop_mode |=> analog_pin_en == '0 && !start_reg
		&& port_data_out == '1)
		else $error("stop did not cancel pin functions");
	a_min_length: assert property ( // [RULE20]
		s_fast_start |=> s_no_early_done)
		else $error("conversion finished too early");
	a_pin_mode_map: assert property ( // [RULE2] [RULE3]
		!ctrl_rst ##1 !ctrl_rst |->
		analog_pin_en[3:0] == $past(mode1_reg)
		&& analog_pin_en[8] == $past(mode2_reg[3]))
		else $error("analog pin selection mismatch");

endmodule : adcsq_top
